// [hw/voltage_detect_pkg.sv]
// Constants, offsets and types shared by the supply voltage detector files.
// Assumes a 100 MHz pclk; every count of cycles is derived from that period.
package voltage_detect_pkg;

	// ************************************************
	// Register byte addresses on APB
	// ************************************************
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_FLAG    = 8'h04;
	localparam logic [7:0] ADDR_IRQ_EN  = 8'h08;
	localparam logic [7:0] ADDR_INTCTL  = 8'h0c;

	// ************************************************
	// Field positions
	// ************************************************
	localparam int DIR_BIT     = 7;
	localparam int BG_BIT      = 6;
	localparam int REF_BIT     = 5;
	localparam int EN_BIT      = 4;
	localparam int FLAG_BIT    = 2;
	localparam int IRQ_EN_BIT  = 2;
	localparam int GIE_BIT     = 7;

	// ************************************************
	// Reset values and codes
	// ************************************************
	localparam logic [3:0] TRIP_RESET    = 4'h4;
	localparam logic [3:0] EXTERNAL_CODE = 4'hf;
	localparam int         TAP_COUNT     = 15;

	// ************************************************
	// Settle timing
	// ************************************************
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          SETTLE_TIME_NS = 20000;
	localparam int          SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] SETTLE_LAST    = 12'(SETTLE_CYCLES - 1);

	typedef enum logic [1:0] {
		SETTLE_OFF  = 2'b00,
		SETTLE_WAIT = 2'b01,
		SETTLE_DONE = 2'b10
	} settle_state_type;

	function automatic logic external_mode(input logic [3:0] level);
		return level == EXTERNAL_CODE;
	endfunction : external_mode

endpackage : voltage_detect_pkg

// [hw/reference_settle_timer.sv]
// Settle timer for the detector reference.
// Assumes enable comes from a register in the same pclk domain.
`timescale 1ns/1ps
module reference_settle_timer (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control and status
	input  wire logic enable,
	output logic      stable
);
	typedef struct packed {
		voltage_detect_pkg::settle_state_type state;
		logic [11:0]                          count;
		logic                                 stable;
	} timer_type;

	timer_type s_reg;
	timer_type s_next;

	always_comb begin
		s_next = s_reg;
		case (s_reg.state)
			voltage_detect_pkg::SETTLE_OFF: begin
				s_next.stable = 1'b0;
				s_next.count  = 12'h000;
				// Every fresh enable restarts the full interval
				if (enable) begin
					s_next.state = voltage_detect_pkg::SETTLE_WAIT;
				end
			end
			voltage_detect_pkg::SETTLE_WAIT: begin
				if (!enable) begin
					s_next.state = voltage_detect_pkg::SETTLE_OFF;
				end else if (s_reg.count == voltage_detect_pkg::SETTLE_LAST) begin
					s_next.state  = voltage_detect_pkg::SETTLE_DONE;
					s_next.stable = 1'b1;
				end else begin
					s_next.count = s_reg.count + 12'h001;
				end
			end
			voltage_detect_pkg::SETTLE_DONE: begin
				if (!enable) begin
					s_next.state  = voltage_detect_pkg::SETTLE_OFF;
					s_next.stable = 1'b0;
				end
			end
			default: begin
				s_next.state  = voltage_detect_pkg::SETTLE_OFF;
				s_next.stable = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{voltage_detect_pkg::SETTLE_OFF, 12'h000, 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign stable = s_reg.stable;

endmodule : reference_settle_timer

// [hw/trip_point_select.sv]
// Trip point selection and direction compare for the detector.
// Assumes comparator results are synchronous, high when supply is above tap.
`timescale 1ns/1ps
module trip_point_select (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Settings
	input  wire logic [3:0]  trip_level,
	input  wire logic        direction_select,
	// Comparator results
	input  wire logic [14:0] supply_above_tap,
	input  wire logic        external_trip_input,
	// Results
	output logic             trip_hit,
	output logic             external_select
);
	typedef struct packed {
		logic hit;
		logic ext_sel;
	} select_type;

	select_type  s_reg;
	select_type  s_next;
	logic [15:0] tap_vec;

	// Code 0 is the lowest tap, code 14 the highest
	genvar i;
	generate
		for (i = 0; i < voltage_detect_pkg::TAP_COUNT; i++) begin : g_tap
			assign tap_vec[i] = supply_above_tap[i];
		end
	endgenerate
	assign tap_vec[15] = external_trip_input;

	always_comb begin
		s_next         = s_reg;
		s_next.ext_sel = voltage_detect_pkg::external_mode(trip_level);
		// Falling watch trips below the point, rising watch above it
		s_next.hit     = direction_select ? tap_vec[trip_level] : !tap_vec[trip_level];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{1'b0, 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign trip_hit        = s_reg.hit;
	assign external_select = s_reg.ext_sel;

	dir_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
		!direction_select && !tap_vec[trip_level] |=> trip_hit)
		else $error("falling watch missed a low supply");

endmodule : trip_point_select

// [hw/supply_voltage_detect_ctrl.sv]
// Control, flag and APB register logic of the supply voltage detector.
// Assumes an APB3 master on pclk; analog results arrive already synchronous.
`timescale 1ns/1ps
module supply_voltage_detect_ctrl (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Analog side
	input  wire logic [14:0] supply_above_tap,
	input  wire logic        external_trip_input,
	input  wire logic        bandgap_ready,
	output logic             detector_power,
	output logic             external_select,
	// System side
	output logic             irq_request,
	output logic             wake_request
);
	// ************************************************
	// State
	// ************************************************
	typedef struct packed {
		logic        direction;
		logic        enable;
		logic [3:0]  level;
		logic        flag;
		logic        irq_en;
		logic        global_irq_enable;
		logic        bg;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        irq;
		logic        wake;
		logic        power;
	} ctrl_type;

	ctrl_type s_reg;
	ctrl_type s_next;
	logic     ref_stable;
	logic     trip_hit;
	logic     access;
	logic     setup;
	logic     clear_req;
	logic     mapped;

	// ************************************************
	// Submodules
	// ************************************************
	reference_settle_timer u_settle (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (s_reg.enable),
		.stable  (ref_stable)
	);

	trip_point_select u_trip (
		.pclk                (pclk),
		.presetn             (presetn),
		.trip_level          (s_reg.level),
		.direction_select    (s_reg.direction),
		.supply_above_tap    (supply_above_tap),
		.external_trip_input (external_trip_input),
		.trip_hit            (trip_hit),
		.external_select     (external_select)
	);

	// ************************************************
	// Bus decode
	// ************************************************
	assign setup     = psel && !penable;
	assign access    = psel && penable && s_reg.pready;
	assign clear_req = access && pwrite && paddr == voltage_detect_pkg::ADDR_FLAG
		&& pwdata[voltage_detect_pkg::FLAG_BIT];

	always_comb begin
		if (paddr == voltage_detect_pkg::ADDR_CONTROL) begin
			mapped = 1'b1;
		end else if (paddr == voltage_detect_pkg::ADDR_FLAG) begin
			mapped = 1'b1;
		end else if (paddr == voltage_detect_pkg::ADDR_IRQ_EN) begin
			mapped = 1'b1;
		end else if (paddr == voltage_detect_pkg::ADDR_INTCTL) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	// ************************************************
	// Next state
	// ************************************************
	always_comb begin
		s_next         = s_reg;
		s_next.bg      = bandgap_ready;
		s_next.pready  = setup;
		s_next.pslverr = setup && !mapped;
		if (!setup) begin
			s_next.prdata = 32'h0000_0000;
		end else if (paddr == voltage_detect_pkg::ADDR_CONTROL) begin
			// Status bits come from live state, never from written data
			s_next.prdata = {24'h00_0000, s_reg.direction, s_reg.bg, ref_stable, s_reg.enable, s_reg.level};
		end else if (paddr == voltage_detect_pkg::ADDR_FLAG) begin
			s_next.prdata = 32'(s_reg.flag) << voltage_detect_pkg::FLAG_BIT;
		end else if (paddr == voltage_detect_pkg::ADDR_IRQ_EN) begin
			s_next.prdata = 32'(s_reg.irq_en) << voltage_detect_pkg::IRQ_EN_BIT;
		end else if (paddr == voltage_detect_pkg::ADDR_INTCTL) begin
			s_next.prdata = 32'(s_reg.global_irq_enable) << voltage_detect_pkg::GIE_BIT;
		end else begin
			s_next.prdata = 32'h0000_0000;
		end

		if (access && pwrite) begin
			if (paddr == voltage_detect_pkg::ADDR_CONTROL) begin
				s_next.direction = pwdata[voltage_detect_pkg::DIR_BIT];
				s_next.enable    = pwdata[voltage_detect_pkg::EN_BIT];
				s_next.level     = pwdata[3:0];
			end else if (paddr == voltage_detect_pkg::ADDR_IRQ_EN) begin
				s_next.irq_en = pwdata[voltage_detect_pkg::IRQ_EN_BIT];
			end else if (paddr == voltage_detect_pkg::ADDR_INTCTL) begin
				s_next.global_irq_enable = pwdata[voltage_detect_pkg::GIE_BIT];
			end
		end

		// Set beats a clear in the same cycle, so no event is lost
		if (clear_req) begin
			s_next.flag = 1'b0;
		end
		if (trip_hit && ref_stable && s_reg.enable) begin
			s_next.flag = 1'b1;
		end

		s_next.power = s_reg.enable;
		s_next.irq   = s_reg.flag && s_reg.irq_en && s_reg.global_irq_enable;
		// Wake needs no clock gating here: the compare path never stops
		s_next.wake  = s_reg.flag && s_reg.enable;
	end

	// ************************************************
	// Registers
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg       <= '0;
			s_reg.level <= voltage_detect_pkg::TRIP_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pready         = s_reg.pready;
	assign prdata         = s_reg.prdata;
	assign pslverr        = s_reg.pslverr;
	assign detector_power = s_reg.power;
	assign irq_request    = s_reg.irq;
	assign wake_request   = s_reg.wake;

	// ************************************************
	// Checks
	// ************************************************
	flag_needs_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s_reg.flag) |-> $past(ref_stable) && $past(s_reg.enable))
		else $error("detect flag rose without a stable reference");

	settle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s_reg.enable) |-> !ref_stable ##1 !ref_stable [*8])
		else $error("reference stable came too soon after enable");

	disable_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!s_reg.enable |=> !ref_stable && !detector_power)
		else $error("disabled detector still powered or stable");

	flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.flag && !clear_req |=> s_reg.flag)
		else $error("detect flag dropped without a clear");

	// Wake only follows while still enabled; a disable in the trip cycle drops it
	trip_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
		trip_hit && ref_stable && s_reg.enable |=> s_reg.flag and (s_reg.enable |=> wake_request))
		else $error("trip did not set flag and wake");

	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq_request |-> $past(s_reg.flag) && $past(s_reg.irq_en) && $past(s_reg.global_irq_enable))
		else $error("interrupt request without flag and both enables");

	status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && paddr == voltage_detect_pkg::ADDR_CONTROL |=> prdata[5] == $past(ref_stable))
		else $error("control read shows wrong reference stable bit");

	ext_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.level == voltage_detect_pkg::EXTERNAL_CODE && $stable(s_reg.level) |=> external_select)
		else $error("external input not routed for code all ones");

endmodule : supply_voltage_detect_ctrl

// [test/testbench.sv]
// Self-checking bench for the supply voltage detector control block.
// Assumes the design files are compiled first; drives APB and the analog inputs.
`timescale 1ns/1ps
module testbench;

	// ************************************************
	// Signals
	// ************************************************
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [14:0] supply_above_tap;
	logic        external_trip_input;
	logic        bandgap_ready;
	logic        detector_power;
	logic        external_select;
	logic        irq_request;
	logic        wake_request;
	logic [31:0] rdata;
	logic        rerr;
	int          err_count;
	int          checked;

	supply_voltage_detect_ctrl uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.supply_above_tap(supply_above_tap), .external_trip_input(external_trip_input),
		.bandgap_ready(bandgap_ready), .detector_power(detector_power),
		.external_select(external_select), .irq_request(irq_request), .wake_request(wake_request)
	);

	always #5 pclk = ~pclk;

	// ************************************************
	// Tasks
	// ************************************************
	task automatic close_out;
		$display("Mismatches %0d, comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			$display("[ERR] %0t no pready", $time);
			close_out();
		end
		rdata = prdata;
		rerr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
		apb(1'b1, addr, wd);
		check(32'(rerr), 32'h0, "write error");
	endtask : wr

	task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		check(32'(rerr), 32'h0, "read error");
		check(rdata, exp, "read data");
	endtask : rd

	// Live pin read; an output launched by the last edge plus one flop stage has settled by now
	task automatic pin(ref logic got, input logic exp, input string what);
		repeat (2) @(negedge pclk);
		check(32'(got), 32'(exp), what);
		@(posedge pclk);
	endtask : pin

	task automatic supply(input logic [14:0] taps, input logic ext);
		@(posedge pclk);
		supply_above_tap    <= taps;
		external_trip_input <= ext;
		repeat (4) @(posedge pclk);
	endtask : supply

	function automatic logic [31:0] ctl(input logic dir, bg, rs, en, input logic [3:0] lvl);
		return {24'h0, dir, bg, rs, en, lvl};
	endfunction : ctl

	// Polls the stable status; gives up well past the settle interval
	task automatic wait_stable;
		int n;
		n = 0;
		do begin
			apb(1'b0, voltage_detect_pkg::ADDR_CONTROL, 32'h0);
			n++;
		end while (rdata[voltage_detect_pkg::REF_BIT] !== 1'b1 && n < 1500);
		check(32'(rdata[voltage_detect_pkg::REF_BIT]), 32'h1, "stable");
		repeat (4) @(posedge pclk);
	endtask : wait_stable

	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		supply_above_tap = 15'h7fff;
		external_trip_input = 1'b0;
		bandgap_ready = 1'b0;
		err_count = 0;
		checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(voltage_detect_pkg::ADDR_CONTROL, ctl(0, 0, 0, 0, 4'h4));
		rd(voltage_detect_pkg::ADDR_FLAG, 32'h0);
		rd(voltage_detect_pkg::ADDR_IRQ_EN, 32'h0);
		rd(voltage_detect_pkg::ADDR_INTCTL, 32'h0);
		pin(detector_power, 1'b0, "power after reset");
		apb(1'b1, 8'h10, 32'hff);
		check(32'(rerr), 32'h1, "unmapped write");
		apb(1'b0, 8'h10, 32'h0);
		check({rdata[30:0], rerr}, 32'h1, "unmapped read");
		// Status bits ignore writes
		wr(voltage_detect_pkg::ADDR_CONTROL, 32'h6f);
		rd(voltage_detect_pkg::ADDR_CONTROL, ctl(0, 0, 0, 0, 4'hf));
		pin(external_select, 1'b1, "external mode");
		bandgap_ready <= 1'b1;
		rd(voltage_detect_pkg::ADDR_CONTROL, ctl(0, 1, 0, 0, 4'hf));
		wr(voltage_detect_pkg::ADDR_CONTROL, ctl(0, 0, 0, 0, 4'h3));
		pin(external_select, 1'b0, "internal mode");
		supply(15'h0000, 1'b0);
		rd(voltage_detect_pkg::ADDR_FLAG, 32'h0);
		pin(detector_power, 1'b0, "power off");
		// Falling watch on tap 3, crossing held through the settle interval
		wr(voltage_detect_pkg::ADDR_CONTROL, ctl(0, 0, 0, 1, 4'h3));
		pin(detector_power, 1'b1, "power on");
		supply(15'h0007, 1'b0);
		repeat (1780) @(posedge pclk);
		rd(voltage_detect_pkg::ADDR_FLAG, 32'h0);
		rd(voltage_detect_pkg::ADDR_CONTROL, ctl(0, 1, 0, 1, 4'h3));
		wait_stable();
		rd(voltage_detect_pkg::ADDR_FLAG, 32'h4);
		supply(15'h7fff, 1'b0);
		rd(voltage_detect_pkg::ADDR_FLAG, 32'h4);
		pin(wake_request, 1'b1, "wake");
		wr(voltage_detect_pkg::ADDR_IRQ_EN, 32'h4);
		pin(irq_request, 1'b0, "irq without global");
		wr(voltage_detect_pkg::ADDR_INTCTL, 32'h80);
		repeat (3) @(posedge pclk);
		pin(irq_request, 1'b1, "irq");
		wr(voltage_detect_pkg::ADDR_FLAG, 32'h4);
		repeat (3) @(posedge pclk);
		rd(voltage_detect_pkg::ADDR_FLAG, 32'h0);
		pin(irq_request, 1'b0, "irq cleared");
		// Rising watch; re-enable must restart the settle interval
		wr(voltage_detect_pkg::ADDR_CONTROL, ctl(1, 0, 0, 0, 4'h3));
		wr(voltage_detect_pkg::ADDR_CONTROL, ctl(1, 0, 0, 1, 4'h3));
		rd(voltage_detect_pkg::ADDR_CONTROL, ctl(1, 1, 0, 1, 4'h3));
		wait_stable();
		rd(voltage_detect_pkg::ADDR_FLAG, 32'h4);
		for (int lvl = 0; lvl < 15; lvl++) begin
			supply(15'((1 << lvl) - 1), 1'b0);
			wr(voltage_detect_pkg::ADDR_CONTROL, ctl(1, 0, 0, 1, 4'(lvl)));
			wr(voltage_detect_pkg::ADDR_FLAG, 32'h4);
			repeat (3) @(posedge pclk);
			rd(voltage_detect_pkg::ADDR_FLAG, 32'h0);
			supply(15'((1 << (lvl + 1)) - 1), 1'b0);
			rd(voltage_detect_pkg::ADDR_FLAG, 32'h4);
		end
		wr(voltage_detect_pkg::ADDR_CONTROL, ctl(1, 0, 0, 1, 4'hf));
		wr(voltage_detect_pkg::ADDR_FLAG, 32'h4);
		repeat (3) @(posedge pclk);
		rd(voltage_detect_pkg::ADDR_FLAG, 32'h0);
		supply(15'h7fff, 1'b1);
		rd(voltage_detect_pkg::ADDR_FLAG, 32'h4);
		wr(voltage_detect_pkg::ADDR_CONTROL, ctl(1, 0, 0, 0, 4'hf));
		pin(detector_power, 1'b0, "power off again");
		close_out();
	end

endmodule : testbench
